// *** rtl/bwm_break_cmp.sv ***
// Purpose: Value comparison of one breakpoint pair
// Assumes: Fetch lanes are little-endian byte offsets of the committed bytes
// Notes:   Purely combinational; qualification and linking are done by the parent
`timescale 1ns/1ps
module bwm_break_cmp (
  input  wire logic [31:0] value_word,
  input  wire logic [31:0] control_word,
  input  wire logic [31:0] fetch_virtual_address,
  input  wire logic [3:0]  fetch_lanes,
  input  wire logic [31:0] context_id,
  output logic             addr_hit,
  output logic             ctx_eq
);

  logic       word_eq;
  logic       lanes_hit;
  logic [3:0] bsel;

  assign bsel      = control_word[bwm_pkg::BSEL_LSB +: 4];
  assign word_eq   = (value_word & bwm_pkg::ADDR_WORD_MASK) ==
                     (fetch_virtual_address & bwm_pkg::ADDR_WORD_MASK);
  assign lanes_hit = bwm_pkg::lane_hit(bsel, fetch_lanes);

  // Mismatch reverses the whole address and byte compare
  assign addr_hit  = control_word[bwm_pkg::MISM_BIT] ? !(word_eq && lanes_hit)
                                                     : (word_eq && lanes_hit);
  assign ctx_eq    = (value_word == context_id);

endmodule // bwm_break_cmp

// *** rtl/bwm_match.sv ***
// Purpose: Breakpoint and watchpoint pair registers and hit generation
// Assumes: All inputs come from core logic on core_clk; rst is the debug logic reset
// Notes:   Comparisons use copies of the registers taken at synchronisation events
`timescale 1ns/1ps
module bwm_match #(
  parameter int NUM_BP        = 6,
  parameter int NUM_WP        = 2,
  parameter int NUM_CTX_BP    = 2,
  parameter bit HAS_MISMATCH  = 1'b1
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Debug register port
  input  wire logic              reg_wr_en,
  input  wire logic              reg_rd_en,
  input  wire logic [6:0]        reg_num,
  input  wire logic [31:0]       reg_wdata,
  output logic [31:0]            reg_rdata,
  // Synchronisation events
  input  wire logic              pipeline_refetch_op,
  input  wire logic              exc_entry,
  input  wire logic              exc_return,
  // Core state
  input  wire logic [31:0]       context_id,
  input  wire logic              core_privileged,
  input  wire logic              monitor_mode_sel,
  input  wire logic              bytecode_state,
  // Instruction side
  input  wire logic              fetch_valid,
  input  wire logic [31:0]       fetch_virtual_address,
  input  wire logic [3:0]        fetch_lanes,
  input  wire logic              fetch_is_opcode,
  // Data side
  input  wire logic              data_valid,
  input  wire logic [31:0]       data_virtual_address,
  input  wire logic [3:0]        data_lanes,
  input  wire logic              data_is_load,
  input  wire logic              data_is_store,
  // Hits
  output logic [NUM_BP-1:0]      bp_hit,
  output logic [NUM_WP-1:0]      wp_hit
);

  localparam int LINK_SPACE = 1 << bwm_pkg::PAIR_IDX_W;

  typedef struct packed {
    logic [NUM_BP-1:0][31:0] bval;
    logic [NUM_BP-1:0][31:0] bctl;
    logic [NUM_BP-1:0][31:0] bval_act;
    logic [NUM_BP-1:0][31:0] bctl_act;
    logic [NUM_WP-1:0][31:0] wval;
    logic [NUM_WP-1:0][31:0] wctl;
    logic [NUM_WP-1:0][31:0] wval_act;
    logic [NUM_WP-1:0][31:0] wctl_act;
    logic [NUM_BP-1:0]       bp_hit;
    logic [NUM_WP-1:0]       wp_hit;
    logic [31:0]             rdata;
  } bwm_state_t;

  bwm_state_t state_r;
  bwm_state_t state_nxt;

  logic [NUM_BP-1:0]     bp_addr_hit;
  logic [NUM_BP-1:0]     bp_ctx_eq;
  logic [NUM_WP-1:0]     wp_local_hit;

  // Writable bits of one break control word, per pair capability
  function automatic logic [31:0] break_ctl_mask(input int idx);
    logic [31:0] m;
    m = bwm_pkg::BREAK_CTL_WMASK;
    if (idx < NUM_BP - NUM_CTX_BP) begin
      m[bwm_pkg::CTX_BIT] = 1'b0;
    end
    if (!HAS_MISMATCH) begin
      m[bwm_pkg::MISM_BIT] = 1'b0;
    end
    return m;
  endfunction

  // Bits 21:20 of a break control word
  function automatic logic [1:0] link_mode(input logic [31:0] ctl);
    return ctl[bwm_pkg::LINK_EN_BIT +: 2];
  endfunction

  // Register numbers of implemented pairs
  function automatic logic bp_idx_ok(input logic [3:0] n);
    return int'(n) < NUM_BP;
  endfunction

  function automatic logic wp_idx_ok(input logic [3:0] n);
    return int'(n) < NUM_WP;
  endfunction

  // One comparator per pair
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BP; gi++) begin : g_bp
      bwm_break_cmp u_cmp (
        .value_word            (state_r.bval_act[gi]),
        .control_word          (state_r.bctl_act[gi]),
        .fetch_virtual_address (fetch_virtual_address),
        .fetch_lanes           (fetch_lanes),
        .context_id            (context_id),
        .addr_hit              (bp_addr_hit[gi]),
        .ctx_eq                (bp_ctx_eq[gi])
      );
    end
    for (gi = 0; gi < NUM_WP; gi++) begin : g_wp
      bwm_watch_cmp u_cmp (
        .watch_value           (state_r.wval_act[gi]),
        .watch_control         (state_r.wctl_act[gi]),
        .data_valid            (data_valid),
        .data_virtual_address  (data_virtual_address),
        .data_lanes            (data_lanes),
        .data_is_load          (data_is_load),
        .data_is_store         (data_is_store),
        .core_privileged       (core_privileged),
        .local_hit             (wp_local_hit[gi])
      );
    end
  endgenerate

  always_comb begin
    logic [LINK_SPACE-1:0]            ctx_ok;
    logic                             sync_evt;
    logic                             op_ok;
    logic                             own_priv;
    logic                             quiet;
    logic [1:0]                       mode;
    logic [bwm_pkg::PAIR_IDX_W-1:0]   lnk;
    logic [3:0]                       idx;

    ctx_ok    = '0;
    sync_evt  = 1'b0;
    op_ok     = 1'b0;
    own_priv  = 1'b0;
    quiet     = 1'b0;
    mode      = 2'h0;
    lnk       = '0;
    idx       = reg_num[3:0];
    state_nxt = state_r;

    // Register writes
    if (reg_wr_en) begin
      case (reg_num[6:4])
        bwm_pkg::GRP_BREAK_VALUE: begin
          if (bp_idx_ok(idx)) begin
            state_nxt.bval[idx] = reg_wdata;
          end
        end
        bwm_pkg::GRP_BREAK_CONTROL: begin
          if (bp_idx_ok(idx)) begin
            state_nxt.bctl[idx] = reg_wdata & break_ctl_mask(int'(idx));
          end
        end
        bwm_pkg::GRP_WATCH_VALUE: begin
          if (wp_idx_ok(idx)) begin
            state_nxt.wval[idx] = reg_wdata & bwm_pkg::WATCH_VAL_WMASK;
          end
        end
        bwm_pkg::GRP_WATCH_CONTROL: begin
          if (wp_idx_ok(idx)) begin
            state_nxt.wctl[idx] = reg_wdata & bwm_pkg::WATCH_CTL_WMASK;
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads, zero for unimplemented numbers
    if (reg_rd_en) begin
      state_nxt.rdata = bwm_pkg::REG_RESET;
      case (reg_num[6:4])
        bwm_pkg::GRP_BREAK_VALUE: begin
          if (bp_idx_ok(idx)) begin
            state_nxt.rdata = state_r.bval[idx];
          end
        end
        bwm_pkg::GRP_BREAK_CONTROL: begin
          if (bp_idx_ok(idx)) begin
            state_nxt.rdata = state_r.bctl[idx];
          end
        end
        bwm_pkg::GRP_WATCH_VALUE: begin
          if (wp_idx_ok(idx)) begin
            state_nxt.rdata = state_r.wval[idx];
          end
        end
        bwm_pkg::GRP_WATCH_CONTROL: begin
          if (wp_idx_ok(idx)) begin
            state_nxt.rdata = state_r.wctl[idx];
          end
        end
        default: begin
        end
      endcase
    end

    // Comparators see new settings only at a synchronisation point
    sync_evt = pipeline_refetch_op || exc_entry || exc_return;
    // Copies include a write of the same cycle, so it is not lost
    if (sync_evt) begin
      state_nxt.bval_act = state_nxt.bval;
      state_nxt.bctl_act = state_nxt.bctl;
      state_nxt.wval_act = state_nxt.wval;
      state_nxt.wctl_act = state_nxt.wctl;
    end

    // Context-target pairs usable by linkers; context_id is compared live
    for (int i = 0; i < NUM_BP; i++) begin
      ctx_ok[i] = state_r.bctl_act[i][bwm_pkg::EN_BIT] &&
                  (link_mode(state_r.bctl_act[i]) ==
                   bwm_pkg::MODE_CTX_TARGET) &&
                  bp_ctx_eq[i];
    end

    // Operand bytes of byte-code never break
    op_ok = fetch_valid && (!bytecode_state || fetch_is_opcode);

    for (int i = 0; i < NUM_BP; i++) begin
      mode     = link_mode(state_r.bctl_act[i]);
      lnk      = state_r.bctl_act[i][bwm_pkg::LINK_LSB +: bwm_pkg::PAIR_IDX_W];
      own_priv = bwm_pkg::priv_ok(state_r.bctl_act[i][bwm_pkg::PRIV_LSB +: 2],
                                  core_privileged);
      // Keeps a monitor handler from trapping on its own code
      quiet    = monitor_mode_sel && core_privileged;
      state_nxt.bp_hit[i] = 1'b0;
      if (state_r.bctl_act[i][bwm_pkg::EN_BIT] && op_ok && own_priv) begin
        if (state_r.bctl_act[i][bwm_pkg::MISM_BIT]) begin
          // 0b10 mismatch; 0b11 reserved never hits
          state_nxt.bp_hit[i] = !state_r.bctl_act[i][bwm_pkg::CTX_BIT] &&
                                bp_addr_hit[i] && !quiet;
        end else begin
          case (mode)
            bwm_pkg::MODE_ADDR: begin
              state_nxt.bp_hit[i] = bp_addr_hit[i];
            end
            bwm_pkg::MODE_ADDR_LINKED: begin
              state_nxt.bp_hit[i] = bp_addr_hit[i] && (lnk != i[3:0]) &&
                                    ctx_ok[lnk];
            end
            bwm_pkg::MODE_CTX: begin
              state_nxt.bp_hit[i] = bp_ctx_eq[i] && !quiet;
            end
            default: begin
              state_nxt.bp_hit[i] = 1'b0;
            end
          endcase
        end
      end
    end

    // Watch links use the target's enable, mode and context
    for (int j = 0; j < NUM_WP; j++) begin
      lnk = state_r.wctl_act[j][bwm_pkg::LINK_LSB +: bwm_pkg::PAIR_IDX_W];
      state_nxt.wp_hit[j] = wp_local_hit[j] &&
                            (!state_r.wctl_act[j][bwm_pkg::LINK_EN_BIT] ||
                             ctx_ok[lnk]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      // Enables clear on debug logic reset
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reg_rdata = state_r.rdata;
  assign bp_hit    = state_r.bp_hit;
  assign wp_hit    = state_r.wp_hit;

endmodule // bwm_match

// *** rtl/bwm_pkg.sv ***
// Purpose: Shared constants and decode helpers for breakpoint/watchpoint matching
// Assumes: Register numbers 64..127 on the core debug register port
// Notes:   Byte lanes are little-endian offsets within the word
package bwm_pkg;

  // Register number groups (reg_num[6:4]) and the pair index width
  localparam logic [2:0] GRP_BREAK_VALUE   = 3'h4;
  localparam logic [2:0] GRP_BREAK_CONTROL = 3'h5;
  localparam logic [2:0] GRP_WATCH_VALUE   = 3'h6;
  localparam logic [2:0] GRP_WATCH_CONTROL = 3'h7;
  localparam int         PAIR_IDX_W        = 4;

  // Control word fields
  localparam int EN_BIT      = 0;
  localparam int PRIV_LSB    = 1;
  localparam int ACC_LSB     = 3;
  localparam int BSEL_LSB    = 5;
  localparam int LINK_LSB    = 16;
  localparam int LINK_EN_BIT = 20;
  localparam int CTX_BIT     = 21;
  localparam int MISM_BIT    = 22;

  // Writable bits and reset values
  localparam logic [31:0] BREAK_CTL_WMASK = 32'h007F_01E7;
  localparam logic [31:0] WATCH_CTL_WMASK = 32'h001F_01FF;
  localparam logic [31:0] WATCH_VAL_WMASK = 32'hFFFF_FFFC;
  localparam logic [31:0] ADDR_WORD_MASK  = 32'hFFFF_FFFC;
  localparam logic [31:0] REG_RESET       = 32'h0000_0000;

  // Privilege qualifier encodings
  localparam logic [1:0] PRIV_PRIVILEGED = 2'h1;
  localparam logic [1:0] PRIV_USER       = 2'h2;
  localparam logic [1:0] PRIV_EITHER     = 2'h3;

  // Meaning of bits 21:20
  localparam logic [1:0] MODE_ADDR        = 2'h0;
  localparam logic [1:0] MODE_ADDR_LINKED = 2'h1;
  localparam logic [1:0] MODE_CTX         = 2'h2;
  localparam logic [1:0] MODE_CTX_TARGET  = 2'h3;

  // Privilege qualifier; 00 is reserved and never passes
  function automatic logic priv_ok(input logic [1:0] fld, input logic is_priv);
    case (fld)
      PRIV_PRIVILEGED: priv_ok = is_priv;
      PRIV_USER:       priv_ok = !is_priv;
      PRIV_EITHER:     priv_ok = 1'b1;
      default:         priv_ok = 1'b0;
    endcase
  endfunction

  // Any selected byte lane touched
  function automatic logic lane_hit(input logic [3:0] bsel, input logic [3:0] lanes);
    lane_hit = |(bsel & lanes);
  endfunction

endpackage

// *** rtl/bwm_watch_cmp.sv ***
// Purpose: Local hit of one watchpoint pair, before linking
// Assumes: Swaps raise both load and store; exclusives raise one of them
// Notes:   Combinational
`timescale 1ns/1ps
module bwm_watch_cmp (
  input  wire logic [31:0] watch_value,
  input  wire logic [31:0] watch_control,
  input  wire logic        data_valid,
  input  wire logic [31:0] data_virtual_address,
  input  wire logic [3:0]  data_lanes,
  input  wire logic        data_is_load,
  input  wire logic        data_is_store,
  input  wire logic        core_privileged,
  output logic             local_hit
);

  logic [1:0] acc;
  logic       acc_ok;
  logic       addr_ok;

  assign acc     = watch_control[bwm_pkg::ACC_LSB +: 2];
  assign acc_ok  = (data_is_load && acc[0]) || (data_is_store && acc[1]);
  assign addr_ok = (watch_value[31:2] == data_virtual_address[31:2]) &&
                   bwm_pkg::lane_hit(watch_control[bwm_pkg::BSEL_LSB +: 4], data_lanes);
  assign local_hit = data_valid && watch_control[bwm_pkg::EN_BIT] && acc_ok && addr_ok &&
                     bwm_pkg::priv_ok(watch_control[bwm_pkg::PRIV_LSB +: 2],
                                      core_privileged);

endmodule // bwm_watch_cmp

// *** tb/bwm_core_model.sv ***
// Purpose: Core pipeline model issuing committed fetches and data accesses
// Assumes: Each call drives one cycle from a falling edge
// Notes:   Idle address, lane and opcode lines show the inverse of their last value; valid, load and store lines go to zero
`timescale 1ns/1ps
module bwm_core_model (
  input  wire logic core_clk,
  output logic        fetch_valid,
  output logic [31:0] fetch_virtual_address,
  output logic [3:0]  fetch_lanes,
  output logic        fetch_is_opcode,
  output logic        data_valid,
  output logic [31:0] data_virtual_address,
  output logic [3:0]  data_lanes,
  output logic        data_is_load,
  output logic        data_is_store
);
  initial begin
    {fetch_valid, fetch_virtual_address, fetch_lanes, fetch_is_opcode} = '0;
    {data_valid, data_virtual_address, data_lanes, data_is_load, data_is_store} = '0;
  end

  task automatic fetch(input logic [31:0] a, input logic [3:0] ln, input logic op);
    @(negedge core_clk);
    {fetch_valid, fetch_virtual_address, fetch_lanes, fetch_is_opcode} = {1'h1, a, ln, op};
    @(negedge core_clk);
    {fetch_valid, fetch_virtual_address, fetch_lanes, fetch_is_opcode} = {1'h0, ~a, ~ln, ~op};
  endtask

  // Swap raises both kinds, exclusives one
  task automatic access(input logic [31:0] a, input logic [3:0] ln, input logic ld,
                        input logic st);
    @(negedge core_clk);
    {data_valid, data_virtual_address, data_lanes, data_is_load, data_is_store} =
      {1'h1, a, ln, ld, st};
    @(negedge core_clk);
    {data_valid, data_virtual_address, data_lanes, data_is_load, data_is_store} =
      {1'h0, ~a, ~ln, 2'h0};
  endtask
endmodule // bwm_core_model

// *** tb/bwm_match_props.sv ***
// Purpose: Port-level checks on the breakpoint/watchpoint match block
// Assumes: One clock domain; rst synchronous, active high
// Notes:   Bound into every instance of the match block
`timescale 1ns/1ps
module bwm_match_props #(
  parameter int NUM_BP = 6,
  parameter int NUM_WP = 2
) (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              reg_rd_en,
  input wire logic [6:0]        reg_num,
  input wire logic [31:0]       reg_rdata,
  input wire logic              bytecode_state,
  input wire logic              fetch_valid,
  input wire logic              fetch_is_opcode,
  input wire logic              data_valid,
  input wire logic              data_is_load,
  input wire logic              data_is_store,
  input wire logic [NUM_BP-1:0] bp_hit,
  input wire logic [NUM_WP-1:0] wp_hit
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  reset_clear_a: assert property ($fell(rst) |-> bp_hit == '0 && wp_hit == '0
    && reg_rdata == 32'h0) else $error("state not clear after reset");
  fetch_gate_a: assert property (!fetch_valid |=> bp_hit == '0)
    else $error("break hit without fetch");
  data_gate_a: assert property (!data_valid |=> wp_hit == '0)
    else $error("watch hit without access");
  opcode_gate_a: assert property (bytecode_state && !fetch_is_opcode |=> bp_hit == '0)
    else $error("break hit on operand fetch");
  access_gate_a: assert property (!data_is_load && !data_is_store |=> wp_hit == '0)
    else $error("watch hit without load or store");
  watch_val_a: assert property (reg_rd_en && reg_num[6:4] == bwm_pkg::GRP_WATCH_VALUE
    |=> reg_rdata[1:0] == 2'h0) else $error("watch value low bits not zero");
  break_ctl_a: assert property (reg_rd_en && reg_num[6:4] == bwm_pkg::GRP_BREAK_CONTROL
    |=> (reg_rdata & ~bwm_pkg::BREAK_CTL_WMASK) == '0) else $error("break control bad bits");
  watch_ctl_a: assert property (reg_rd_en && reg_num[6:4] == bwm_pkg::GRP_WATCH_CONTROL
    |=> (reg_rdata & ~bwm_pkg::WATCH_CTL_WMASK) == '0) else $error("watch control bad bits");
endmodule // bwm_match_props

bind bwm_match bwm_match_props #(.NUM_BP(NUM_BP), .NUM_WP(NUM_WP)) u_props (
  .core_clk(core_clk), .rst(rst), .reg_rd_en(reg_rd_en), .reg_num(reg_num),
  .reg_rdata(reg_rdata), .bytecode_state(bytecode_state), .fetch_valid(fetch_valid),
  .fetch_is_opcode(fetch_is_opcode), .data_valid(data_valid), .data_is_load(data_is_load),
  .data_is_store(data_is_store), .bp_hit(bp_hit), .wp_hit(wp_hit)
);

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the match block
// Assumes: Inputs change on the falling edge; hits read one cycle later
// Notes:   Pair 4 and 5 are the context-capable pairs
`timescale 1ns/1ps
module tb_top;
  logic        core_clk = 1'h0, rst = 1'h1, reg_wr_en = 1'h0, reg_rd_en = 1'h0;
  logic [6:0]  reg_num = 7'h0;
  logic [31:0] reg_wdata = 32'h0, context_id = 32'h0, reg_rdata;
  logic        pipeline_refetch_op = 1'h0, exc_entry = 1'h0, exc_return = 1'h0;
  logic        core_privileged = 1'h1, monitor_mode_sel = 1'h0, bytecode_state = 1'h0;
  logic        fetch_valid, fetch_is_opcode, data_valid, data_is_load, data_is_store;
  logic [31:0] fetch_virtual_address, data_virtual_address;
  logic [3:0]  fetch_lanes, data_lanes;
  logic [5:0]  bp_hit;
  logic [1:0]  wp_hit, sync_sel = 2'h0;
  int          error_cnt = 0, tests_run = 0;

  always #2 core_clk = ~core_clk;

  bwm_core_model core (.core_clk(core_clk), .fetch_valid(fetch_valid),
    .fetch_virtual_address(fetch_virtual_address), .fetch_lanes(fetch_lanes),
    .fetch_is_opcode(fetch_is_opcode), .data_valid(data_valid),
    .data_virtual_address(data_virtual_address), .data_lanes(data_lanes),
    .data_is_load(data_is_load), .data_is_store(data_is_store));

  bwm_match dut (.core_clk(core_clk), .rst(rst), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_num(reg_num), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pipeline_refetch_op(pipeline_refetch_op), .exc_entry(exc_entry), .exc_return(exc_return),
    .context_id(context_id), .core_privileged(core_privileged),
    .monitor_mode_sel(monitor_mode_sel), .bytecode_state(bytecode_state),
    .fetch_valid(fetch_valid), .fetch_virtual_address(fetch_virtual_address),
    .fetch_lanes(fetch_lanes), .fetch_is_opcode(fetch_is_opcode), .data_valid(data_valid),
    .data_virtual_address(data_virtual_address), .data_lanes(data_lanes),
    .data_is_load(data_is_load), .data_is_store(data_is_store), .bp_hit(bp_hit),
    .wp_hit(wp_hit));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] n, input logic [31:0] d);
    @(negedge core_clk);
    {reg_wr_en, reg_num, reg_wdata} = {1'h1, n, d};
    @(negedge core_clk);
    reg_wr_en = 1'h0;
  endtask

  task automatic rd(input logic [6:0] n, output logic [31:0] d);
    @(negedge core_clk);
    {reg_rd_en, reg_num} = {1'h1, n};
    @(negedge core_clk);
    reg_rd_en = 1'h0;
    d = reg_rdata;
  endtask

  // Rotates through the three synchronising events
  task automatic sync();
    @(negedge core_clk);
    {exc_return, exc_entry, pipeline_refetch_op} = 3'h1 << sync_sel;
    sync_sel = (sync_sel == 2'h2) ? 2'h0 : sync_sel + 2'h1;
    @(negedge core_clk);
    {exc_return, exc_entry, pipeline_refetch_op} = 3'h0;
  endtask

  // Mode is bits 22:20
  function automatic logic [31:0] bctl(input logic [2:0] md, input logic [3:0] lk,
                                       input logic [3:0] bs, input logic [1:0] pv);
    return {9'h0, md, lk, 7'h0, bs, 2'h0, pv, 1'h1};
  endfunction

  task automatic fb(input logic [31:0] a, input logic [3:0] ln, input logic op,
                    input logic [5:0] exp);
    core.fetch(a, ln, op);
    chk(32'(bp_hit), 32'(exp));
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [6:0]  n [6] = '{7'h40, 7'h50, 7'h55, 7'h60, 7'h70, 7'h00};
    logic [31:0] e [6] = '{32'hFFFFFFFF, 32'h005F01E7, 32'h007F01E7, 32'hFFFFFFFC,
                           32'h001F01FF, 32'h0};
    rd(7'h70, d);
    chk(d, 32'h0);
    foreach (n[i]) wr(n[i], '1);
    foreach (n[i]) begin
      rd(n[i], d);
      chk(d, e[i]);
    end
    foreach (n[i]) wr(n[i], '0);
  endtask

  task automatic t_priv();
    logic x;
    wr(7'h40, 32'h1000);
    wr(7'h50, bctl(3'h0, 4'h0, 4'hF, 2'h3));
    fb(32'h1000, 4'hF, 1'h1, 6'h00);
    for (int p = 0; p < 4; p++) begin
      wr(7'h50, bctl(3'h0, 4'h0, 4'hF, 2'(p)));
      sync();
      for (int k = 0; k < 2; k++) begin
        core_privileged = k[0];
        x = (p == 3) || (p == 1 && k == 1) || (p == 2 && k == 0);
        fb(32'h1000, 4'hF, 1'h1, {5'h0, x});
      end
    end
  endtask

  task automatic t_bsel();
    logic [2:0]  md;
    logic [3:0]  bs, ln;
    logic [31:0] a;
    logic        x;
    logic [43:0] rows [8] = '{{3'h0, 4'h3, 32'h1000, 4'h1, 1'h1}, {3'h0, 4'h3, 32'h1000, 4'h4, 1'h0},
      {3'h0, 4'h0, 32'h1000, 4'hF, 1'h0}, {3'h0, 4'hF, 32'h1004, 4'hF, 1'h0},
      {3'h4, 4'h0, 32'h1000, 4'hF, 1'h1}, {3'h4, 4'h3, 32'h1000, 4'h2, 1'h0},
      {3'h4, 4'h3, 32'h1000, 4'h4, 1'h1}, {3'h4, 4'hF, 32'h2000, 4'hF, 1'h1}};
    foreach (rows[i]) begin
      {md, bs, a, ln, x} = rows[i];
      wr(7'h50, bctl(md, 4'h0, bs, 2'h3));
      sync();
      fb(a, ln, 1'h1, {5'h0, x});
    end
    wr(7'h50, 32'h0);
  endtask

  task automatic t_ctx();
    wr(7'h44, 32'h55);
    wr(7'h54, bctl(3'h2, 4'h0, 4'hF, 2'h3));
    sync();
    context_id = 32'h55;
    fb(32'h8, 4'hF, 1'h1, 6'h10);
    monitor_mode_sel = 1'h1;
    fb(32'h8, 4'hF, 1'h1, 6'h00);
    core_privileged = 1'h0;
    fb(32'h8, 4'hF, 1'h1, 6'h10);
    context_id = 32'h56;
    fb(32'h8, 4'hF, 1'h1, 6'h00);
    {context_id, bytecode_state} = {32'h55, 1'h1};
    fb(32'h8, 4'hF, 1'h0, 6'h00);
    fb(32'h8, 4'hF, 1'h1, 6'h10);
    {bytecode_state, monitor_mode_sel, core_privileged} = 3'h1;
    wr(7'h54, 32'h0);
  endtask

  task automatic t_link();
    wr(7'h45, 32'h77);
    wr(7'h55, bctl(3'h3, 4'h0, 4'hF, 2'h3));
    wr(7'h41, 32'h2000);
    wr(7'h51, bctl(3'h1, 4'h5, 4'hF, 2'h1));
    wr(7'h42, 32'h2000);
    wr(7'h52, bctl(3'h0, 4'h5, 4'hF, 2'h3));
    sync();
    context_id = 32'h77;
    fb(32'h2000, 4'hF, 1'h1, 6'h06);
    context_id = 32'h78;
    fb(32'h2000, 4'hF, 1'h1, 6'h04);
    {context_id, core_privileged} = {32'h77, 1'h0};
    fb(32'h2000, 4'hF, 1'h1, 6'h04);
    core_privileged = 1'h1;
    wr(7'h55, bctl(3'h3, 4'h0, 4'hF, 2'h3) ^ 32'h1);
    sync();
    fb(32'h2000, 4'hF, 1'h1, 6'h04);
  endtask

  task automatic t_watch();
    wr(7'h60, 32'h3000);
    for (int a = 0; a < 4; a++) begin
      wr(7'h70, {23'h0, 4'hF, 2'(a), 2'h3, 1'h1});
      sync();
      for (int k = 1; k < 4; k++) begin
        core.access(32'h3000, 4'hF, k[0], k[1]);
        chk(32'(wp_hit), 32'((a & k) != 0));
      end
    end
    wr(7'h55, bctl(3'h3, 4'h0, 4'hF, 2'h3));
    wr(7'h70, {11'h0, 1'h1, 4'h5, 7'h0, 4'hF, 2'h3, 2'h3, 1'h1});
    sync();
    core.access(32'h3000, 4'hF, 1'h1, 1'h0);
    chk(32'(wp_hit), 32'h1);
    context_id = 32'h78;
    core.access(32'h3000, 4'hF, 1'h1, 1'h0);
    chk(32'(wp_hit), 32'h0);
  endtask

  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #20000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(negedge core_clk);
    rst = 1'h0;
    t_regs();
    t_priv();
    t_bsel();
    t_ctx();
    t_link();
    t_watch();
    tally_and_finish();
  end
endmodule // tb_top
